// ### async_serial_consts.vh
`ifndef ASYNC_SERIAL_CONSTS_VH
`define ASYNC_SERIAL_CONSTS_VH
// Register offsets (word index on the plain register port)
`define OFS_BAUD          3'h0
`define OFS_CTRL          3'h1
`define OFS_STATUS        3'h2
`define OFS_DATA          3'h3
`define OFS_STATDATA      3'h4
// Control field positions
`define CB_BREAK          0
`define CB_SLEEP          1
`define CB_RX_EN          2
`define CB_TX_EN          3
`define CB_IDLE_IE        4
`define CB_RXF_IE         5
`define CB_DONE_IE        6
`define CB_EMPTY_IE       7
`define CB_WAKE           8
`define CB_M              9
`define CB_PAR_EN         10
`define CB_PAR_ODD        11
`define CB_IDLE_TYPE      12
// Status field positions
`define SB_PAR_ERR        0
`define SB_FRAME_ERR      1
`define SB_NOISE          2
`define SB_OVERRUN        3
`define SB_IDLE           4
`define SB_BUSY           5
`define SB_RX_FULL        6
`define SB_TX_DONE        7
`define SB_TX_EMPTY       8
// Reset values
`define CTRL_RESET        16'h0000
`define STATUS_RESET      9'h180
`define BAUD_RESET        13'h0004
// Timing: samples per bit
`define SAMPLES_PER_BIT   16
// Idle line: last sample index of 10 or 11 bit times of ones
`define IDLE_TICKS_SHORT  8'h9F
`define IDLE_TICKS_LONG   8'hAF
`endif

// ### async_serial_port.v
`timescale 1ns/100ps
`default_nettype none
`include "async_serial_consts.vh"
module async_serial_port #(
  parameter BAUD_WIDTH = 13
) (
  input  wire        ref_clk,      // System clock
  input  wire        reset_n,      // Synchronous reset, active low
  input  wire [2:0]  reg_addr,     // Register index
  input  wire [15:0] reg_wdata,    // Write data
  input  wire        reg_wr,       // Write strobe
  input  wire        reg_rd,       // Read strobe
  output reg  [15:0] reg_rdata,    // Read data, cycle after strobe
  input  wire        rxd,          // Serial receive line
  output reg         txd_out,      // Transmit line level
  output reg         txd_oe_n,     // Low while the serial port drives the pin
  output reg         irq           // Interrupt request, active high
);
  // Control and baud registers
  reg [BAUD_WIDTH-1:0] baud_div;
  reg [15:0]           ctrl;
  wire tx_enable             = ctrl[`CB_TX_EN];
  wire rx_enable             = ctrl[`CB_RX_EN];
  wire rx_sleep_mode         = ctrl[`CB_SLEEP];
  wire send_break_ctrl       = ctrl[`CB_BREAK];
  wire nine_bit              = ctrl[`CB_M];
  wire parity_enable         = ctrl[`CB_PAR_EN];
  wire parity_odd_select     = ctrl[`CB_PAR_ODD];
  wire idle_count_type       = ctrl[`CB_IDLE_TYPE];
  // Status flags and arm bits
  reg [8:0] status;
  reg [8:0] armed;
  reg       idle_rearm;
  reg [8:0] tx_buffer;
  reg [8:0] rx_buffer;
  // Sample-rate tick from divider
  reg [BAUD_WIDTH-1:0] div_cnt;
  reg                  tick;
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      div_cnt <= {BAUD_WIDTH{1'b0}};
      tick    <= 1'b0;
    end else if (baud_div == {BAUD_WIDTH{1'b0}}) begin
      div_cnt <= {BAUD_WIDTH{1'b0}};
      tick    <= 1'b0;
    end else if (div_cnt >= baud_div - 1'b1) begin
      div_cnt <= {BAUD_WIDTH{1'b0}};
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      tick    <= 1'b0;
    end
  end
  // Bus decode
  wire st_rd   = reg_rd && (reg_addr == `OFS_STATUS || reg_addr == `OFS_STATDATA);
  wire dat_rd  = reg_rd && (reg_addr == `OFS_DATA || reg_addr == `OFS_STATDATA);
  wire dat_wr  = reg_wr && reg_addr == `OFS_DATA;
  wire combo   = reg_rd && reg_addr == `OFS_STATDATA;
  // Parity of the data bits that precede the parity slot
  wire [8:0] tx_word = tx_buffer;
  wire       tx_par  = (nine_bit ? ^tx_word[7:0] : ^tx_word[6:0]) ^ parity_odd_select;
  // Transmitter
  localparam TX_IDLE = 3'b001;
  localparam TX_SEND = 3'b010;
  localparam TX_DONE = 3'b100;
  reg [2:0]  tx_state;
  reg [10:0] tx_shift;
  reg [3:0]  tx_bits;
  reg [3:0]  tx_sub;
  reg        pre_pend;
  reg        te_prev;
  reg        tx_buffer_empty_flag_set;
  reg        tc_set;
  reg        tx_active;
  wire [3:0] frame_len = nine_bit ? 4'd11 : 4'd10;
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      tx_state  <= TX_IDLE;
      tx_shift  <= 11'h7FF;
      tx_bits   <= 4'h0;
      tx_sub    <= 4'h0;
      pre_pend  <= 1'b0;
      te_prev   <= 1'b0;
      tx_buffer_empty_flag_set  <= 1'b0;
      tc_set    <= 1'b0;
      tx_active <= 1'b0;
    end else begin
      te_prev  <= tx_enable;
      tx_buffer_empty_flag_set <= 1'b0;
      tc_set   <= 1'b0;
      if (tx_enable && !te_prev)
        pre_pend <= 1'b1;
      case (tx_state)
        TX_IDLE: begin
          if (tick && tx_enable) begin
            tx_sub  <= 4'h0;
            tx_bits <= frame_len;
            tx_state <= TX_SEND;
            tx_active <= 1'b1;
            if (pre_pend) begin
              tx_shift <= 11'h7FF;
              pre_pend <= 1'b0;
            end else if (send_break_ctrl) begin
              tx_shift <= 11'h000;
            end else if (!status[`SB_TX_EMPTY]) begin
              if (nine_bit)
                tx_shift <= {1'b1, parity_enable ? tx_par : tx_word[8], tx_word[7:0], 1'b0};
              else
                tx_shift <= {2'b11, parity_enable ? tx_par : tx_word[7], tx_word[6:0], 1'b0};
              tx_buffer_empty_flag_set <= 1'b1;
            end else begin
              tx_state  <= TX_IDLE;
              tx_active <= 1'b0;
              tc_set    <= 1'b1;
            end
          end else if (!tx_enable) begin
            tx_active <= 1'b0;
            tc_set    <= 1'b1;
          end
        end
        TX_SEND: begin
          if (tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == 4'hF) begin
              tx_shift <= {1'b1, tx_shift[10:1]};
              tx_bits  <= tx_bits - 4'h1;
              if (tx_bits == 4'h1)
                tx_state <= TX_DONE;
            end
          end
        end
        TX_DONE: begin
          tx_state <= TX_IDLE;
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      txd_out  <= 1'b1;
      txd_oe_n <= 1'b1;
    end else begin
      txd_out  <= (tx_state == TX_SEND) ? tx_shift[0] : 1'b1;
      txd_oe_n <= !(tx_enable || tx_active);
    end
  end
  // Receiver
  reg [3:0]  rx_sub;
  reg [3:0]  rx_bits;
  reg        rx_run;
  reg [10:0] rx_shift;
  reg [1:0]  vote;
  reg        noise_acc;
  reg [7:0]  ones_cnt;
  reg        ones_count_on;
  reg        rx_prev;
  reg        rx_buffer_full_flag_set;
  reg        nf_set;
  reg        fe_set;
  reg        pf_set;
  reg        or_set;
  reg        idle_set;
  reg        wake;
  wire       rx_quiet = !rx_enable || rx_sleep_mode;
  wire       maj = (vote[1] & vote[0]) | (vote[1] & rxd) | (vote[0] & rxd);
  wire       bit_noise = !(vote[1] == vote[0] && vote[0] == rxd);
  // Received word fields: data at [9:2] or [9:1], stop always at [10]
  wire [8:0] rx_word = nine_bit ? rx_shift[9:1] : {1'b0, rx_shift[9:2]};
  wire       rx_last = rx_shift[9];
  wire       rx_parok = ((nine_bit ? ^rx_shift[9:1] : ^rx_shift[9:2]) == parity_odd_select);
  // Idle needs a whole frame of ones, counted in samples
  wire [7:0] idle_len = nine_bit ? `IDLE_TICKS_LONG : `IDLE_TICKS_SHORT;
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      rx_sub <= 4'h0;
      rx_bits <= 4'h0;
      rx_run <= 1'b0;
      rx_shift <= 11'h000;
      vote <= 2'b00;
      noise_acc <= 1'b0;
      ones_cnt <= 8'h00;
      ones_count_on <= 1'b0;
      rx_prev <= 1'b1;
      rx_buffer_full_flag_set <= 1'b0;
      nf_set <= 1'b0;
      fe_set <= 1'b0;
      pf_set <= 1'b0;
      or_set <= 1'b0;
      idle_set <= 1'b0;
      wake <= 1'b0;
      rx_buffer <= 9'h000;
    end else begin
      rx_buffer_full_flag_set <= 1'b0;
      nf_set <= 1'b0;
      fe_set <= 1'b0;
      pf_set <= 1'b0;
      or_set <= 1'b0;
      idle_set <= 1'b0;
      wake <= 1'b0;
      if (!rx_enable) begin
        rx_run <= 1'b0;
        ones_cnt <= 8'h00;
      end else if (tick) begin
        rx_prev <= rxd;
        // idle count, short type counts any one outside a frame
        if (!rxd)
          ones_cnt <= 8'h00;
        else if ((ones_count_on || !idle_count_type) && !rx_run && ones_cnt != 8'hFF)
          ones_cnt <= ones_cnt + 8'h01;
        // idle detect after 10 or 11 bit times of ones
        if (ones_cnt == idle_len) begin
          ones_cnt <= 8'h00;
          if (rx_sleep_mode && !ctrl[`CB_WAKE])
            wake <= 1'b1;
          else if (!rx_sleep_mode)
            idle_set <= 1'b1;
        end
        if (!rx_run) begin
          if (rx_prev && !rxd) begin
            rx_run <= 1'b1;
            rx_sub <= 4'h1;
            rx_bits <= 4'h0;
            noise_acc <= 1'b0;
          end
        end else begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub == 4'h2 || rx_sub == 4'h4)
            vote <= {vote[0], rxd};
          if (rx_sub == 4'h6) begin
            if (rx_bits == 4'h0 && maj) begin
              rx_run <= 1'b0;
            end else begin
              rx_shift <= {maj, rx_shift[10:1]};
              noise_acc <= noise_acc | bit_noise;
              rx_bits <= rx_bits + 4'h1;
            end
          end
          if (rx_sub == 4'hF && rx_bits == frame_len) begin
            rx_run <= 1'b0;
            ones_count_on <= 1'b1;
            ones_cnt <= 8'h00;
            if (rx_sleep_mode) begin
              if (ctrl[`CB_WAKE] && rx_last)
                wake <= 1'b1;
            end else if (status[`SB_RX_FULL] || status[`SB_OVERRUN]) begin
              or_set <= 1'b1;
            end else begin
              rx_buffer <= rx_word;
              rx_buffer_full_flag_set <= 1'b1;
              nf_set <= noise_acc;
              fe_set <= !rx_shift[10];
              pf_set <= parity_enable && !rx_parok;
            end
          end
        end
      end
    end
  end
  // Receiver-active tracks the run state
  wire raf_now = rx_run && rx_enable;
  // Register writes and status flags
  wire [8:0] set_vec = {tx_buffer_empty_flag_set, tc_set, rx_buffer_full_flag_set, 1'b0, idle_set && idle_rearm,
                        or_set, nf_set, fe_set, pf_set};
  wire [8:0] rx_mask = 9'h05F;
  wire [8:0] tx_mask = 9'h180;
  reg  [8:0] clr_vec;
  always @* begin
    clr_vec = 9'h000;
    // receive flags on data read, transmit flags on data write
    if (dat_rd)
      clr_vec = clr_vec | (armed & rx_mask);
    if (dat_wr)
      clr_vec = clr_vec | (armed & tx_mask);
    // Combined read clears receive flags set at read time
    if (combo)
      clr_vec = clr_vec | (status & rx_mask);
  end
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl <= `CTRL_RESET;
      baud_div <= `BAUD_RESET;
      status <= `STATUS_RESET;
      armed <= 9'h000;
      idle_rearm <= 1'b1;
      tx_buffer <= 9'h000;
    end else begin
      if (reg_wr && reg_addr == `OFS_CTRL)
        ctrl <= reg_wdata;
      else if (wake)
        ctrl[`CB_SLEEP] <= 1'b0;
      if (reg_wr && reg_addr == `OFS_BAUD)
        baud_div <= reg_wdata[BAUD_WIDTH-1:0];
      if (dat_wr)
        tx_buffer <= reg_wdata[8:0];
      status <= ((status & ~clr_vec) | (set_vec & {2'b11, {7{!rx_quiet}}}));
      status[`SB_BUSY] <= raf_now;
      if (st_rd && !combo)
        armed <= status;
      else if (st_rd)
        armed <= armed & ~clr_vec | (status & tx_mask);
      else
        armed <= armed & ~clr_vec;
      if (rx_buffer_full_flag_set)
        idle_rearm <= 1'b1;
      else if (idle_set && idle_rearm && !rx_quiet)
        idle_rearm <= 1'b0;
    end
  end
  // Combined read arms only the transmit flags from current status
  // Read data
  always @(posedge ref_clk) begin
    if (!reset_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd) begin
      case (reg_addr)
        `OFS_BAUD:     reg_rdata <= {{(16-BAUD_WIDTH){1'b0}}, baud_div};
        `OFS_CTRL:     reg_rdata <= ctrl;
        `OFS_STATUS:   reg_rdata <= {7'h00, status};
        `OFS_DATA:     reg_rdata <= {7'h00, rx_buffer};
        `OFS_STATDATA: reg_rdata <= {status[7:0], rx_buffer[7:0]};
        default:       reg_rdata <= 16'h0000;
      endcase
    end else
      reg_rdata <= 16'h0000;
  end
  always @(posedge ref_clk) begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= (status[`SB_TX_EMPTY] & ctrl[`CB_EMPTY_IE]) |
             (status[`SB_TX_DONE] & ctrl[`CB_DONE_IE]) |
             (!rx_sleep_mode & ((status[`SB_RX_FULL] & ctrl[`CB_RXF_IE]) |
                                (status[`SB_IDLE] & ctrl[`CB_IDLE_IE])));
  end
endmodule
`default_nettype wire

// ### async_serial_port_properties.sv
`timescale 1ns/100ps
`default_nettype none
module async_serial_port_checker (
  input wire logic        ref_clk,   // Clock
  input wire logic        reset_n,   // Reset, active low
  input wire logic [2:0]  reg_addr,  // Index
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic        reg_wr,    // Write strobe
  input wire logic        reg_rd,    // Read strobe
  input wire logic [15:0] reg_rdata, // Read data
  input wire logic        rxd,       // Line in
  input wire logic        txd_out,   // Line out
  input wire logic        txd_oe_n,  // Pin owned when low
  input wire logic        irq        // Interrupt
);
  logic [15:0] ctrl;
  logic [12:0] baud;
  logic [19:0] low_run;
  logic        tx_seen;
  logic        rx_seen;
  // Shadow of software writes to control and baud
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl    <= 16'h0000;
      baud    <= 13'h0004;
      tx_seen <= 1'b0;
      rx_seen <= 1'b0;
    end else if (reg_wr && reg_addr == 3'h1) begin
      ctrl    <= reg_wdata;
      tx_seen <= tx_seen | reg_wdata[3];
      rx_seen <= rx_seen | reg_wdata[2];
    end else if (reg_wr && reg_addr == 3'h0) begin
      baud <= reg_wdata[12:0];
    end
  end
  // Length of the present low stretch on the line
  always @(posedge ref_clk) begin
    if (!reset_n || txd_out) begin
      low_run <= 20'h0_0000;
    end else begin
      low_run <= low_run + 20'h0_0001;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  AST_STATUS_TOP: assert property (
    $past(reg_rd) && $past(reg_addr) == 3'h2 |-> reg_rdata[15:9] == 7'h00)
    else $error("status upper bits set");
  AST_RX_OFF_QUIET: assert property (
    !rx_seen && $past(reg_rd) && $past(reg_addr) == 3'h2 |-> (reg_rdata & 16'h005F) == 16'h0000)
    else $error("receiver flag while receiver off");
  AST_TXE_IRQ: assert property (
    $past(reg_rd) && $past(reg_addr) == 3'h2 && reg_rdata[8] && ctrl[7] && $past(ctrl[7])
    |-> ##[0:2] irq)
    else $error("tx empty irq missing");
  AST_TXD_IRQ: assert property (
    $past(reg_rd) && $past(reg_addr) == 3'h2 && reg_rdata[7] && ctrl[6] && $past(ctrl[6])
    |-> ##[0:2] irq)
    else $error("tx done irq missing");
  AST_RXF_IRQ: assert property (
    $past(reg_rd) && $past(reg_addr) == 3'h2 && reg_rdata[6] && ctrl[5] && !ctrl[1]
    |-> ##[0:2] irq)
    else $error("rx full irq missing");
  AST_IDLE_IRQ: assert property (
    $past(reg_rd) && $past(reg_addr) == 3'h2 && reg_rdata[4] && ctrl[4] && !ctrl[1]
    |-> ##[0:2] irq)
    else $error("idle irq missing");
  AST_IRQ_MASKED: assert property (
    ctrl[7:4] == 4'h0 && $past(ctrl[7:4]) == 4'h0 && $past(ctrl[7:4], 2) == 4'h0 |-> !irq)
    else $error("irq with all enables clear");
  AST_PIN_TAKEN: assert property (
    $rose(ctrl[3]) |-> ##[0:2] !txd_oe_n)
    else $error("pin not taken by transmitter");
  AST_PIN_FREE: assert property (
    !tx_seen |-> txd_oe_n)
    else $error("pin driven before transmitter enable");
  AST_BIT_TIME: assert property (
    $rose(txd_out) && !txd_oe_n |-> low_run >= {3'h0, baud, 4'h0})
    else $error("low pulse shorter than one bit");
endmodule
bind async_serial_port async_serial_port_checker chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd),
  .txd_out(txd_out), .txd_oe_n(txd_oe_n), .irq(irq)
);
`default_nettype wire

// ### serial_partner_model.sv
`timescale 1ns/100ps
`default_nettype none
module serial_partner_model #(
  parameter int BIT = 32
) (
  input  wire logic       ref_clk,  // Clock
  input  wire logic       txd_out,  // Line from the port
  input  wire logic       txd_oe_n, // Port drives when low
  input  wire logic       nine,     // Nine data bits
  output var  logic       rxd,      // Line to the port
  output var  logic [8:0] rx_word   // Last word heard
);
  int i;
  // Line marks idle from time zero
  initial begin
    rxd     = 1'b1;
    rx_word = 9'h000;
  end
  task automatic send(input logic [8:0] d, input int nb);
    rxd <= 1'b0;
    repeat (BIT) @(posedge ref_clk);
    for (int k = 0; k < nb; k++) begin
      rxd <= d[k];
      repeat (BIT) @(posedge ref_clk);
    end
    rxd <= 1'b1;
    repeat (BIT) @(posedge ref_clk);
  endtask
  always begin
    @(negedge txd_out);
    if (!txd_oe_n) begin
      rx_word = 9'h000;
      repeat (BIT / 2) @(posedge ref_clk);
      for (i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (BIT) @(posedge ref_clk);
        rx_word[i] = txd_out;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int BIT = 32;
  logic        ref_clk   = 1'b0;
  logic        reset_n   = 1'b0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        nine      = 1'b0;
  logic [2:0]  reg_addr  = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [15:0] word;
  logic [8:0]  rx_word;
  logic        rxd;
  logic        txd_out;
  logic        txd_oe_n;
  logic        irq;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycles    = 0;
  // Clock
  always #25 ref_clk = ~ref_clk;
  async_serial_port dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd),
    .txd_out(txd_out), .txd_oe_n(txd_oe_n), .irq(irq)
  );
  serial_partner_model #(.BIT(BIT)) partner (
    .ref_clk(ref_clk), .txd_out(txd_out), .txd_oe_n(txd_oe_n), .nine(nine),
    .rxd(rxd), .rx_word(rx_word)
  );
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [15:0] exp, input logic [15:0] mask);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata & mask, exp, $sformatf("reg %0d", a));
  endtask
  task automatic bits(input int n);
    repeat (n * BIT) @(posedge ref_clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 12000) begin
      bad_count++;
      stop_test();
    end
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    rdc(3'h2, 16'h0180, 16'hFFFF);
    rdc(3'h1, 16'h0000, 16'hFFFF);
    rdc(3'h5, 16'h0000, 16'hFFFF);
    wr(3'h0, 16'h0002);
    wr(3'h2, 16'h0000);
    rdc(3'h2, 16'h0180, 16'hFFFF);
    wr(3'h1, 16'h0088);
    rdc(3'h2, 16'h0180, 16'h0180);
    check({15'h0000, irq}, 16'h0001, "irq");
    wr(3'h1, 16'h0048);
    rdc(3'h2, 16'h0180, 16'h0180);
    check({15'h0000, irq}, 16'h0001, "irq");
    wr(3'h1, 16'h0008);
    bits(1);
    check({15'h0000, irq}, 16'h0000, "irq");
    for (int m = 0; m < 2; m++) begin
      word = m ? 16'h013C : 16'h00A5;
      nine <= m[0];
      wr(3'h1, m ? 16'h0208 : 16'h0008);
      rdc(3'h2, 16'h0180, 16'h0180);
      wr(3'h3, word);
      bits(24);
      check({7'h00, rx_word}, word, "line word");
      rdc(3'h2, 16'h0180, 16'h0180);
    end
    partner.send(9'h033, 8);
    bits(2);
    rdc(3'h2, 16'h0000, 16'h005F);
    wr(3'h1, 16'h0024);
    partner.send(9'h05A, 8);
    bits(12);
    rdc(3'h2, 16'h0050, 16'h005F);
    check({15'h0000, irq}, 16'h0001, "irq");
    rdc(3'h3, 16'h005A, 16'h00FF);
    rdc(3'h2, 16'h0000, 16'h0050);
    check({15'h0000, irq}, 16'h0000, "irq");
    wr(3'h1, 16'h0014);
    partner.send(9'h011, 8);
    partner.send(9'h022, 8);
    bits(12);
    rdc(3'h2, 16'h0058, 16'h005F);
    check({15'h0000, irq}, 16'h0001, "irq");
    rdc(3'h4, 16'h0011, 16'h00FF);
    rdc(3'h2, 16'h0180, 16'h01DF);
    wr(3'h1, 16'h0106);
    partner.send(9'h005, 8);
    bits(2);
    rdc(3'h2, 16'h0000, 16'h0050);
    rdc(3'h1, 16'h0106, 16'hFFFF);
    partner.send(9'h085, 8);
    bits(2);
    rdc(3'h1, 16'h0104, 16'hFFFF);
    wr(3'h1, 16'h0008);
    bits(12);
    wr(3'h1, 16'h0009);
    bits(2);
    check({15'h0000, txd_out}, 16'h0000, "break line");
    wr(3'h1, 16'h0008);
    bits(26);
    check({15'h0000, txd_out}, 16'h0001, "idle line");
    rdc(3'h2, 16'h0180, 16'h0180);
    stop_test();
  end
endmodule
`default_nettype wire
